// File: common/osf_defs.vh
`ifndef OSF_DEFS_VH
`define OSF_DEFS_VH
// Code prefixes
`define OSF_PFX_ERROR 8'hFE
`define OSF_PFX_FATAL 8'hFF
// Cause low bytes
`define OSF_CAUSE_NONE 8'h00
`define OSF_CAUSE_MAIN_TEMP 8'h01
`define OSF_CAUSE_SW_TEMP 8'h02
`define OSF_CAUSE_OVERVOLT 8'h03
`define OSF_CAUSE_SPEED 8'h04
`define OSF_CAUSE_UNDERVOLT 8'h05
`define OSF_CAUSE_ABS_POS 8'h06
`define OSF_CAUSE_INC_POS 8'h07
// Reset value of the code output
`define OSF_CODE_RESET 16'h0000
// Self-diagnosis repeat window
`define OSF_REPEAT_MS 500
`define OSF_CLK_KHZ 200000
`define OSF_REPEAT_CYC (`OSF_REPEAT_MS * `OSF_CLK_KHZ)
// Restart duration after delete-error
`define OSF_RESTART_CYC 16
`endif

// File: core/osf_fault_handler.v
`timescale 1ns/100ps
`include "osf_defs.vh"
module osf_fault_handler #(
  parameter REPEAT_CYC = `OSF_REPEAT_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Speed evaluation (same clock domain)
  input wire speedTrip,
  input wire slipHit,
  // Fault pins, asynchronous
  input wire internal_device_fault,
  input wire main_overtemp_fault,
  input wire switch_overtemp_fault,
  input wire supply_overvoltage_fault,
  input wire excessive_speed_fault,
  input wire supply_undervoltage_fault,
  input wire absolute_position_fault,
  input wire incremental_position_fault,
  // Self-diagnosis (same clock domain)
  input wire diagDone,
  input wire diagFail,
  // Clearing paths
  input wire resetInputCycle,
  input wire deleteError,
  input wire faultRead,
  // Contacts and indicators
  output wire safety_contact_a,
  output wire safety_contact_b,
  output wire diagContact,
  output wire redLamp,
  output wire severe_fault_category,
  output wire inSafeState,
  output wire restartBusy,
  output wire [15:0] faultCode
);
  // States, one-hot
  localparam [3:0] ST_RUN = 4'b0001;
  localparam [3:0] ST_ERROR = 4'b0010;
  localparam [3:0] ST_FATAL = 4'b0100;
  localparam [3:0] ST_RESTART = 4'b1000;

  wire [7:0] pinsSync; // Synchronised fault pins
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [15:0] code_ff; // Latched causing code
  reg [15:0] nxt_code;
  reg [15:0] memCode_ff; // Fault memory
  reg memValid_ff; // Fault memory holds an entry
  reg memRead_ff; // Entry has been read out
  reg contactsClosed_ff; // Safety contacts closed
  reg diagClosed_ff; // Diagnostic contact closed
  reg slipHold_ff; // Slip-angle hold open
  reg retryPend_ff; // First self-check failed
  reg diagSafe_ff; // Repeat check failed too, or no repeat came within the window
  reg [31:0] retryCnt_ff;
  reg [4:0] restartCnt_ff;
  reg [7:0] cause;
  reg anyError;

  osf_sync2 #(
    .WIDTH(8)
  ) uSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({incremental_position_fault, absolute_position_fault, supply_undervoltage_fault,
      excessive_speed_fault, supply_overvoltage_fault, switch_overtemp_fault,
      main_overtemp_fault, internal_device_fault}),
    .syncOut(pinsSync)
  );

  // Error-category cause, lowest code first
  always @* begin
    cause = `OSF_CAUSE_NONE;
    if (pinsSync[1]) cause = `OSF_CAUSE_MAIN_TEMP;
    else if (pinsSync[2]) cause = `OSF_CAUSE_SW_TEMP;
    else if (pinsSync[3]) cause = `OSF_CAUSE_OVERVOLT;
    else if (pinsSync[4]) cause = `OSF_CAUSE_SPEED;
    else if (pinsSync[5]) cause = `OSF_CAUSE_UNDERVOLT;
    else if (pinsSync[6]) cause = `OSF_CAUSE_ABS_POS;
    else if (pinsSync[7]) cause = `OSF_CAUSE_INC_POS;
    anyError = |pinsSync[7:1];
  end

  // Category state machine
  always @* begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    case (state_ff)
      ST_RUN: begin
        // Fatal handling wins when both are pending
        if (pinsSync[0] || diagSafe_ff) begin
          nxt_state = ST_FATAL;
          nxt_code = {`OSF_PFX_FATAL, `OSF_CAUSE_NONE};
        end else if (anyError) begin
          nxt_state = ST_ERROR;
          nxt_code = {`OSF_PFX_ERROR, cause};
        end
      end
      ST_ERROR: begin
        if (pinsSync[0] || diagSafe_ff) begin
          nxt_state = ST_FATAL;
          nxt_code = {`OSF_PFX_FATAL, `OSF_CAUSE_NONE};
        end else if (deleteError) begin
          nxt_state = ST_RESTART;
        end else if (resetInputCycle) begin
          nxt_state = ST_RUN;
          nxt_code = `OSF_CODE_RESET;
        end
      end
      ST_FATAL: begin
        // Reset input is deliberately ignored here
        if (deleteError) nxt_state = ST_RESTART;
      end
      ST_RESTART: begin
        // A fault still present after restart relatches in RUN
        if (restartCnt_ff == `OSF_RESTART_CYC) begin
          nxt_state = ST_RUN;
          nxt_code = `OSF_CODE_RESET;
        end
      end
      default: begin
        nxt_state = ST_FATAL;
        nxt_code = {`OSF_PFX_FATAL, `OSF_CAUSE_NONE};
      end
    endcase
  end

  // State, code, restart counter
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
      code_ff <= `OSF_CODE_RESET;
      restartCnt_ff <= 5'd0;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      if (state_ff == ST_RESTART) restartCnt_ff <= restartCnt_ff + 5'd1;
      else restartCnt_ff <= 5'd0;
    end
  end

  // Self-diagnosis repeat window
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      retryPend_ff <= 1'b0;
      diagSafe_ff <= 1'b0;
      retryCnt_ff <= 32'd0;
    end else if (state_ff == ST_RESTART) begin
      // Restart wipes the diagnosis history
      retryPend_ff <= 1'b0;
      diagSafe_ff <= 1'b0;
      retryCnt_ff <= 32'd0;
    end else if (!retryPend_ff) begin
      retryCnt_ff <= 32'd0;
      if (diagDone && diagFail) retryPend_ff <= 1'b1;
    end else begin
      retryCnt_ff <= retryCnt_ff + 32'd1;
      if ((diagDone && diagFail) || retryCnt_ff >= REPEAT_CYC - 1) begin
        diagSafe_ff <= 1'b1;
        retryPend_ff <= 1'b0;
      end else if (diagDone) begin
        retryPend_ff <= 1'b0; // Repeat passed
      end
    end
  end

  // Fault memory and red lamp; a new fault beats a same-cycle delete
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memCode_ff <= `OSF_CODE_RESET;
      memValid_ff <= 1'b0;
      memRead_ff <= 1'b0;
    end else if (state_ff == ST_RUN && nxt_state != ST_RUN) begin
      memCode_ff <= nxt_code;
      memValid_ff <= 1'b1;
      memRead_ff <= 1'b0;
    end else if (memValid_ff) begin
      if (faultRead) memRead_ff <= 1'b1;
      // A delete that loses to a fault escalation must not darken the lamp
      if (deleteError && (memRead_ff || faultRead) && nxt_state != ST_ERROR && nxt_state != ST_FATAL) begin
        memValid_ff <= 1'b0;
      end
    end
  end

  // Contact drive; diagnostic contact is never an input here
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      contactsClosed_ff <= 1'b0;
      diagClosed_ff <= 1'b0;
      slipHold_ff <= 1'b0;
    end else begin
      if (state_ff != ST_RUN) slipHold_ff <= 1'b0;
      else if (speedTrip && slipHit) slipHold_ff <= 1'b1;
      contactsClosed_ff <= (nxt_state == ST_RUN) && !speedTrip && !slipHold_ff
        && !(speedTrip && slipHit);
      diagClosed_ff <= (nxt_state == ST_RUN);
    end
  end

  assign safety_contact_a = contactsClosed_ff;
  assign safety_contact_b = contactsClosed_ff;
  assign diagContact = diagClosed_ff;
  assign redLamp = memValid_ff;
  assign severe_fault_category = (state_ff == ST_FATAL);
  assign inSafeState = (state_ff == ST_ERROR) || (state_ff == ST_FATAL);
  assign restartBusy = (state_ff == ST_RESTART);
  assign faultCode = inSafeState ? code_ff : memCode_ff;
endmodule // osf_fault_handler

// File: core/osf_sync2.v
`timescale 1ns/100ps
// Two flip-flop synchroniser for a bus of pin levels
module osf_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Data
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_ff; // Only read by stage2
  reg [WIDTH-1:0] stage2_ff;

  // Two stages against metastability
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= {WIDTH{1'b0}};
      stage2_ff <= {WIDTH{1'b0}};
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule // osf_sync2

// File: verification/osf_fault_handler_assertions.sv
`timescale 1ns/100ps
// Port-level checks of the fault handler
module osf_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Inputs
  input wire speedTrip,
  input wire slipHit,
  input wire main_overtemp_fault,
  input wire deleteError,
  // Outputs
  input wire safety_contact_a,
  input wire safety_contact_b,
  input wire diagContact,
  input wire redLamp,
  input wire severe_fault_category,
  input wire inSafeState,
  input wire restartBusy,
  input wire [15:0] faultCode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Two sync stages plus the state update
  sequence s_pin; main_overtemp_fault [*4]; endsequence
  sequence s_open; !safety_contact_a && !safety_contact_b && !diagContact; endsequence
  // Relatch may lag a restart by one cycle
  property p_pin; s_pin |-> ##[0:2] (inSafeState || restartBusy); endproperty
  a_pin: assert property (p_pin) else $error("fault pin no trip");
  property p_open; inSafeState |-> s_open; endproperty
  a_open: assert property (p_open) else $error("contact closed");
  property p_fe; inSafeState && !severe_fault_category |-> faultCode[15:8] == 8'hFE; endproperty
  a_fe: assert property (p_fe) else $error("bad error code");
  property p_ff; inSafeState && severe_fault_category |-> faultCode == 16'hFF00; endproperty
  a_ff: assert property (p_ff) else $error("bad fatal code");
  property p_lamp; inSafeState |-> redLamp; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp dark");
  property p_keep; severe_fault_category && !deleteError |=> severe_fault_category; endproperty
  a_keep: assert property (p_keep) else $error("fatal left");
  property p_del; inSafeState && deleteError |=> restartBusy; endproperty
  a_del: assert property (p_del) else $error("no restart");
  property p_slip; speedTrip && slipHit |-> ##[1:2] !(safety_contact_a || safety_contact_b); endproperty
  a_slip: assert property (p_slip) else $error("slip closed");
endmodule // osf_chk
bind osf_fault_handler osf_chk u_chk (.ref_clk, .rst_n, .speedTrip, .slipHit, .main_overtemp_fault,
  .deleteError, .safety_contact_a, .safety_contact_b, .diagContact, .redLamp, .severe_fault_category,
  .inSafeState, .restartBusy, .faultCode);

// File: verification/osf_host_model.sv
`timescale 1ns/100ps
// Plant control and setup tool
module osf_host (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Bench commands
  input wire cmdClear,
  input wire cmdPower,
  // Requests to the block
  output reg faultRead,
  output reg deleteError,
  output reg resetInputCycle
);
  // Read memory first so the lamp may clear
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultRead <= 1'b0;
      deleteError <= 1'b0;
      resetInputCycle <= 1'b0;
    end else begin
      faultRead <= cmdClear;
      deleteError <= faultRead;
      resetInputCycle <= cmdPower;
    end
  end
endmodule // osf_host

// File: verification/osf_testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  reg ref_clk = 0, rst_n = 0, speedTrip = 0, slipHit = 0, diagDone = 0, diagFail = 0;
  reg cmdClear = 0, cmdPower = 0;
  reg [7:0] pin = 8'h00;
  wire rd, del, pwr, sa, sb, dg, lamp, sev, safe, busy;
  wire [15:0] code;
  int err_count = 0, samples_checked = 0, cyc = 0;
  osf_fault_handler #(.REPEAT_CYC(20)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .speedTrip(speedTrip),
    .slipHit(slipHit), .internal_device_fault(pin[0]), .main_overtemp_fault(pin[1]),
    .switch_overtemp_fault(pin[2]), .supply_overvoltage_fault(pin[3]), .excessive_speed_fault(pin[4]),
    .supply_undervoltage_fault(pin[5]), .absolute_position_fault(pin[6]),
    .incremental_position_fault(pin[7]), .diagDone(diagDone), .diagFail(diagFail),
    .resetInputCycle(pwr), .deleteError(del), .faultRead(rd), .safety_contact_a(sa),
    .safety_contact_b(sb), .diagContact(dg), .redLamp(lamp), .severe_fault_category(sev),
    .inSafeState(safe), .restartBusy(busy), .faultCode(code));
  osf_host u_host (.ref_clk(ref_clk), .rst_n(rst_n), .cmdClear(cmdClear), .cmdPower(cmdPower),
    .faultRead(rd), .deleteError(del), .resetInputCycle(pwr));
  initial forever #2.5 ref_clk = ~ref_clk;
  task tick(input int n); repeat (n) @(posedge ref_clk); endtask
  task look; @(negedge ref_clk); endtask
  task clr; cmdClear <= 1; tick(1); cmdClear <= 0; tick(24); endtask
  task pwrCyc; cmdPower <= 1; tick(1); cmdPower <= 0; tick(6); endtask
  task t_codes;
    for (int i = 1; i < 8; i++) begin
      tick(1); pin[i] <= 1; tick(4); look;
      `CHK("code", {8'hFE, i[7:0]}, code)
      `CHK("open", 4'b0001, {sa, sb, dg, lamp})
      tick(1); pin[i] <= 0; clr; look;
      `CHK("run", 4'b1110, {sa, sb, dg, lamp})
    end
    $display("test codes done");
  endtask
  task t_persist;
    tick(1); pin[3] <= 1; tick(4); clr; look;
    `CHK("persist", 17'h1FE03, {safe, code})
    tick(1); pin[3] <= 0; clr;
    $display("test persist done");
  endtask
  task t_power;
    tick(1); pin[2] <= 1; tick(4); pin[2] <= 0; pwrCyc; look;
    `CHK("power", 2'b01, {safe, sa})
    `CHK("memory", 17'h1FE02, {lamp, code})
    $display("test power done");
  endtask
  task t_fatal;
    tick(1); pin[0] <= 1; pin[5] <= 1; tick(4); pin <= 8'h00; pwrCyc; look;
    `CHK("fatal", 18'h3FF00, {sev, safe, code})
    tick(1); cmdClear <= 1; tick(1); cmdClear <= 0; tick(4); look;
    `CHK("restart", 2'b10, {busy, lamp})
    tick(20); look;
    `CHK("fclr", 2'b01, {sev, sa})
    $display("test fatal done");
  endtask
  task t_diag;
    tick(1); diagDone <= 1; diagFail <= 1; tick(1); diagDone <= 0; tick(4); look;
    `CHK("diag1", 1'b0, sev)
    tick(1); diagDone <= 1; tick(1); diagDone <= 0; diagFail <= 0; tick(3); look;
    `CHK("diag2", 2'b11, {sev, safe})
    tick(1); clr;
    $display("test diag done");
  endtask
  task t_slip;
    tick(1); speedTrip <= 1; slipHit <= 1; tick(3); look;
    `CHK("slip", 3'b001, {sa, sb, dg})
    tick(1); speedTrip <= 0; slipHit <= 0; tick(2); look;
    `CHK("hold", 3'b001, {sa, sb, dg})
    $display("test slip done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    tick(4); rst_n <= 1; tick(2);
    t_codes;
    t_persist;
    t_power;
    t_fatal;
    t_diag;
    t_slip;
    conclude;
  end
endmodule // testbench
